// ==== logic/divide_check_unit.sv ====
`timescale 1ns/1ps
module divide_check_unit (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic divzero_trap_en,
    // Divide request
    input wire logic div_valid,
    input wire logic div_signed,
    input wire logic [31:0] div_dividend,
    input wire logic [31:0] div_divisor,
    // Result
    output logic div_done,
    output logic [31:0] div_quotient,
    output logic div_trap
);

    logic div_done_d;
    logic [31:0] div_quotient_d;
    logic div_trap_d;
    logic zero;

    always_comb begin
        zero = (div_divisor == 32'h0);
        div_done_d = 1'b0;
        div_trap_d = 1'b0;
        div_quotient_d = div_quotient;
        if (div_valid) begin
            if (zero && divzero_trap_en) begin
                div_trap_d = 1'b1;
            end else if (zero) begin
                div_done_d = 1'b1;
                div_quotient_d = 32'h0;
            end else if (div_signed) begin
                div_done_d = 1'b1;
                div_quotient_d = 32'($signed(div_dividend)
                                     / $signed(div_divisor));
            end else begin
                div_done_d = 1'b1;
                div_quotient_d = div_dividend / div_divisor;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_done <= 1'b0;
            div_quotient <= 32'h0;
        end else begin
            div_done <= div_done_d;
            div_quotient <= div_quotient_d;
        end
    end

    // Combinational trap: the exception lands one edge after the request
    assign div_trap = div_trap_d;

endmodule

// ==== logic/stack_align_unit.sv ====
`timescale 1ns/1ps
module stack_align_unit (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic stack_align_sel,
    // Entry
    input wire logic entry_valid,
    input wire logic [31:0] entry_sp,
    input wire logic [31:0] entry_psr,
    output logic [31:0] frame_sp,
    output logic [31:0] stacked_psr,
    // Return
    input wire logic return_valid,
    input wire logic [31:0] return_frame_sp,
    input wire logic [31:0] return_stacked_psr,
    output logic [31:0] restored_sp
);

    logic [31:0] frame_sp_d;
    logic [31:0] stacked_psr_d;
    logic [31:0] restored_sp_d;
    logic [2:0] pad;

    always_comb begin
        pad = trap_cfg_pkg::align_pad(entry_sp, stack_align_sel);
        frame_sp_d = frame_sp;
        stacked_psr_d = stacked_psr;
        restored_sp_d = restored_sp;
        if (entry_valid) begin
            frame_sp_d = entry_sp - {29'h0, pad};
            stacked_psr_d = entry_psr;
            stacked_psr_d[trap_cfg_pkg::STACKED_ALIGN_BIT] = pad[2];
        end
        if (return_valid) begin
            restored_sp_d = return_frame_sp;
            if (return_stacked_psr[trap_cfg_pkg::STACKED_ALIGN_BIT]) begin
                restored_sp_d = return_frame_sp | 32'h00000004;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            frame_sp <= 32'h0;
            stacked_psr <= 32'h0;
            restored_sp <= 32'h0;
        end else begin
            frame_sp <= frame_sp_d;
            stacked_psr <= stacked_psr_d;
            restored_sp <= restored_sp_d;
        end
    end

endmodule

// ==== logic/trap_and_fault_config.sv ====
// How it works
// - supervisor call raises its exception; the immediate is ignored. A divide or misalign trap in the same cycle raises EXC_USAGE instead.
// - supervisor call leaves all condition flags unchanged.
// - alignment select 0 gives 4-byte, 1 gives 8-byte; pad in bit 9.
// - exception return restores stack pointer from stacked bit 9.
// - bus-fault ignore set: priority -1/-2 handlers ignore data bus faults.
// - bus-fault ignore clear: such a fault locks up the core.
// - divide trap set: zero divisor faults instead of completing.
// - divide trap clear: zero divisor completes with quotient zero.
// - misalign trap set: unaligned half/word access gives usage fault.
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module trap_and_fault_config (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Instruction side
    input wire logic svc_exec,
    input wire logic [7:0] svc_imm,
    input wire logic [3:0] flags_in,
    output logic [3:0] flags_out,
    // Exception request to the core
    output logic exc_req,
    output logic [8:0] exc_num,
    output logic lockup,
    // Stack alignment
    input wire logic entry_valid,
    input wire logic [31:0] entry_sp,
    input wire logic [31:0] entry_psr,
    output logic [31:0] frame_sp,
    output logic [31:0] stacked_psr,
    input wire logic return_valid,
    input wire logic [31:0] return_frame_sp,
    input wire logic [31:0] return_stacked_psr,
    output logic [31:0] restored_sp,
    // Exception return to thread mode
    input wire logic exc_return_thread,
    input wire logic other_active,
    output logic thread_entry_fault,
    // Data bus faults
    input wire logic data_bus_fault,
    input wire logic high_priority_active,
    output logic bus_fault_suppress,
    // Divide
    input wire logic div_valid,
    input wire logic div_signed,
    input wire logic [31:0] div_dividend,
    input wire logic [31:0] div_divisor,
    output logic div_done,
    output logic [31:0] div_quotient,
    // Memory access check
    input wire logic mem_valid,
    input wire logic [1:0] mem_size,
    input wire logic [1:0] mem_addr_low,
    // Privilege of the bus master
    input wire logic bus_privileged,
    // Software trigger toward the interrupt controller
    output logic swint_valid,
    output logic [8:0] swint_id
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [31:0] config_q, config_d;
    logic [trap_cfg_pkg::FS_WIDTH-1:0] fault_status_q, fault_status_d;
    logic [31:0] avs_readdata_d;
    logic swint_valid_d;
    logic [8:0] swint_id_d;
    logic exc_req_d;
    logic [8:0] exc_num_d;
    logic lockup_q, lockup_d;
    logic thread_entry_fault_d;
    logic bus_fault_suppress_d;
    trap_cfg_pkg::bus_state_t bus_q, bus_d;

    localparam int FS_W = trap_cfg_pkg::FS_WIDTH;
    logic div_trap;
    logic misalign;
    logic access;
    logic hp_fault;
    logic [FS_W-1:0] fs_set;
    logic [FS_W-1:0] fs_clr;

    // The immediate is deliberately unused by the hardware
    logic unused_imm;
    assign unused_imm = ^svc_imm;

    ////////////////////////////////////////////////////////////////////////
    // Sub-units

    stack_align_unit u_stack (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .stack_align_sel(config_q[trap_cfg_pkg::STACK_ALIGN_BIT]),
        .entry_valid(entry_valid),
        .entry_sp(entry_sp),
        .entry_psr(entry_psr),
        .frame_sp(frame_sp),
        .stacked_psr(stacked_psr),
        .return_valid(return_valid),
        .return_frame_sp(return_frame_sp),
        .return_stacked_psr(return_stacked_psr),
        .restored_sp(restored_sp)
    );

    divide_check_unit u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .divzero_trap_en(config_q[trap_cfg_pkg::DIVZERO_TRAP_BIT]),
        .div_valid(div_valid),
        .div_signed(div_signed),
        .div_dividend(div_dividend),
        .div_divisor(div_divisor),
        .div_done(div_done),
        .div_quotient(div_quotient),
        .div_trap(div_trap)
    );

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, answer on the second edge

    assign access = avs_read | avs_write;
    assign avs_waitrequest = access & (bus_q == trap_cfg_pkg::BUS_IDLE);

    always_comb begin
        bus_d = trap_cfg_pkg::BUS_IDLE;
        if (access && bus_q == trap_cfg_pkg::BUS_IDLE) begin
            bus_d = trap_cfg_pkg::BUS_ACK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file and events

    always_comb begin
        config_d = config_q;
        fs_clr = '0;
        fs_set = '0;
        avs_readdata_d = avs_readdata;
        swint_valid_d = 1'b0;
        swint_id_d = swint_id;
        if (bus_q == trap_cfg_pkg::BUS_ACK && avs_write) begin
            case (avs_address)
                trap_cfg_pkg::REG_CONFIG_OFS: begin
                    for (int b = 0; b < 4; b++) begin
                        if (avs_byteenable[b]) begin
                            config_d[b*8 +: 8] = avs_writedata[b*8 +: 8]
                                & trap_cfg_pkg::CONFIG_WRITE_MASK[b*8 +: 8];
                        end
                    end
                end
                trap_cfg_pkg::REG_FAULT_STATUS_OFS: begin
                    if (avs_byteenable[0]) begin
                        fs_clr = avs_writedata[FS_W-1:0];
                    end
                end
                trap_cfg_pkg::REG_SWINT_OFS: begin
                    if (bus_privileged ||
                        config_q[trap_cfg_pkg::USER_SWINT_BIT]) begin
                        swint_valid_d = 1'b1;
                        swint_id_d = avs_writedata[8:0];
                    end else begin
                        fs_set[trap_cfg_pkg::FS_SWINT_DENIED_BIT] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Read data loads in the wait cycle, so it stands at the accept edge
        if (bus_q == trap_cfg_pkg::BUS_IDLE && avs_read) begin
            case (avs_address)
                trap_cfg_pkg::REG_CONFIG_OFS:
                    avs_readdata_d = config_q;
                trap_cfg_pkg::REG_FAULT_STATUS_OFS:
                    avs_readdata_d = {{(32-FS_W){1'b0}}, fault_status_q};
                default:
                    avs_readdata_d = 32'h0;
            endcase
        end
        // Sticky causes; a set in the clearing cycle wins
        // divide cause recorded
        fs_set[trap_cfg_pkg::FS_DIVZERO_BIT] = div_trap;
        fs_set[trap_cfg_pkg::FS_MISALIGN_BIT] = misalign;
        fs_set[trap_cfg_pkg::FS_SVC_BIT] = svc_exec;
        fs_set[trap_cfg_pkg::FS_LOCKUP_BIT] = lockup_d & ~lockup_q;
        fs_set[trap_cfg_pkg::FS_BUS_IGNORED_BIT] = bus_fault_suppress_d;
        fault_status_d = (fault_status_q & ~fs_clr) | fs_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // Trap decisions

    // Half or word access that misses its natural boundary
    function automatic logic unaligned(input logic [1:0] size,
                                       input logic [1:0] low);
        logic hit;
        hit = 1'b0;
        if (size == trap_cfg_pkg::SIZE_HALF) begin
            hit = low[0];
        end else if (size == trap_cfg_pkg::SIZE_WORD) begin
            hit = |low;
        end
        return hit;
    endfunction

    // Data fault taken while a priority -1 or -2 handler runs
    assign hp_fault = data_bus_fault & high_priority_active;

    always_comb begin
        misalign = 1'b0;
        if (mem_valid && config_q[trap_cfg_pkg::MISALIGN_TRAP_BIT]) begin
            misalign = unaligned(mem_size, mem_addr_low);
        end
        exc_req_d = 1'b0;
        exc_num_d = exc_num;
        if (div_trap || misalign) begin
            exc_req_d = 1'b1;
            exc_num_d = trap_cfg_pkg::EXC_USAGE;
        end else if (svc_exec) begin
            exc_req_d = 1'b1;
            exc_num_d = trap_cfg_pkg::EXC_SVC;
        end
        bus_fault_suppress_d = hp_fault
            && config_q[trap_cfg_pkg::BUS_FAULT_IGNORE_BIT];
        lockup_d = lockup_q | (hp_fault
            && !config_q[trap_cfg_pkg::BUS_FAULT_IGNORE_BIT]);
        thread_entry_fault_d = exc_return_thread && other_active
            && !config_q[trap_cfg_pkg::THREAD_ENTRY_BIT];
    end

    assign flags_out = flags_in;
    assign lockup = lockup_q;

    ////////////////////////////////////////////////////////////////////////
    // State registers: bus handshake

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_q <= trap_cfg_pkg::BUS_IDLE;
        end else begin
            bus_q <= bus_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers: register file and trigger

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            config_q <= trap_cfg_pkg::CONFIG_RESET;
            fault_status_q <= '0;
            avs_readdata <= 32'h0;
            swint_valid <= 1'b0;
            swint_id <= 9'h0;
        end else begin
            config_q <= config_d;
            fault_status_q <= fault_status_d;
            avs_readdata <= avs_readdata_d;
            swint_valid <= swint_valid_d;
            swint_id <= swint_id_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers: exception and fault outputs

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            exc_req <= 1'b0;
            exc_num <= 9'h0;
            thread_entry_fault <= 1'b0;
            bus_fault_suppress <= 1'b0;
        end else begin
            exc_req <= exc_req_d;
            exc_num <= exc_num_d;
            thread_entry_fault <= thread_entry_fault_d;
            bus_fault_suppress <= bus_fault_suppress_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers: lock-up, held until reset

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lockup_q <= 1'b0;
        end else begin
            lockup_q <= lockup_d;
        end
    end

endmodule

// ==== logic/trap_cfg_pkg.sv ====
package trap_cfg_pkg;

    // Register map (byte addresses, used unchanged as the bus address)
    localparam logic [3:0] REG_CONFIG_OFS = 4'h0;
    localparam logic [3:0] REG_FAULT_STATUS_OFS = 4'h4;
    localparam logic [3:0] REG_SWINT_OFS = 4'h8;

    // Configuration field positions
    localparam int THREAD_ENTRY_BIT = 0;
    localparam int USER_SWINT_BIT = 1;
    localparam int MISALIGN_TRAP_BIT = 3;
    localparam int DIVZERO_TRAP_BIT = 4;
    localparam int BUS_FAULT_IGNORE_BIT = 8;
    localparam int STACK_ALIGN_BIT = 9;
    localparam logic [31:0] CONFIG_WRITE_MASK = 32'h0000031b;
    localparam logic [31:0] CONFIG_RESET = 32'h00000000;

    // Fault status field positions (write one to clear)
    localparam int FS_DIVZERO_BIT = 0;
    localparam int FS_MISALIGN_BIT = 1;
    localparam int FS_SVC_BIT = 2;
    localparam int FS_LOCKUP_BIT = 3;
    localparam int FS_BUS_IGNORED_BIT = 4;
    localparam int FS_SWINT_DENIED_BIT = 5;
    localparam int FS_WIDTH = 6;

    // Stacked status word position of the alignment pad flag
    localparam int STACKED_ALIGN_BIT = 9;

    // Exception numbers presented to the core
    localparam logic [8:0] EXC_SVC = 9'h00b;
    localparam logic [8:0] EXC_USAGE = 9'h006;
    localparam logic [8:0] SWINT_ID_MAX = 9'h1ef;

    // Access sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_t;

    // Alignment pad needed to reach the selected boundary
    function automatic logic [2:0] align_pad(input logic [31:0] sp,
                                             input logic sel8);
        logic [2:0] pad;
        pad = 3'h0;
        if (sel8 && sp[2]) begin
            pad = 3'h4;
        end
        return pad;
    endfunction

endpackage

// ==== verification/tb_trap_and_fault_config.sv ====
`timescale 1ns/1ps
module tb_trap_and_fault_config;
    localparam logic [3:0] CFG = trap_cfg_pkg::REG_CONFIG_OFS;
    localparam logic [3:0] STS = trap_cfg_pkg::REG_FAULT_STATUS_OFS;
    localparam logic [3:0] SWI = trap_cfg_pkg::REG_SWINT_OFS;
    localparam logic [8:0] USG = trap_cfg_pkg::EXC_USAGE;
    logic clk_sys = 1'h0, rst_n = 1'h0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
    logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic svc_exec = 1'h0, entry_valid = 1'h0, return_valid = 1'h0;
    logic exc_return_thread = 1'h0, other_active = 1'h0;
    logic data_bus_fault = 1'h0, high_priority_active = 1'h0;
    logic div_valid = 1'h0, div_signed = 1'h0, mem_valid = 1'h0;
    logic bus_privileged = 1'h1;
    logic [7:0] svc_imm = 8'h0;
    logic [3:0] flags_in = 4'h0, flags_out;
    logic [1:0] mem_size = 2'h0, mem_addr_low = 2'h0;
    logic [31:0] entry_sp = 32'h0, entry_psr = 32'h0;
    logic [31:0] return_frame_sp = 32'h0, return_stacked_psr = 32'h0;
    logic [31:0] div_dividend = 32'h0, div_divisor = 32'h0;
    logic [31:0] frame_sp, stacked_psr, restored_sp, div_quotient;
    logic exc_req, lockup, thread_entry_fault, bus_fault_suppress;
    logic div_done, swint_valid;
    logic [8:0] exc_num, swint_id;
    int miscompares = 0, check_count = 0;
    trap_and_fault_config dut (.*);
    always #12.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
        int i;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'h0) break;
        end
        if (i == 20) begin
            miscompares++;
            results();
        end
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be = 4'hf);
        logic [31:0] q;
        bus(1'h1, a, d, be, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, 4'hf, q);
        chk(q, exp);
    endtask
    // Kinds: 0 call, 1 unsigned_divide, 2 mem, 3 entry, 4 return, 5 thread, 6 fault,
    // 7 signed_divide; outputs are checked at the negedge after the pulse
    task automatic pulse(input int k, input logic [31:0] a,
        input logic [31:0] b);
        @(posedge clk_sys);
        svc_imm <= a[7:0];
        flags_in <= b[3:0];
        entry_sp <= a;
        entry_psr <= b;
        return_frame_sp <= a;
        return_stacked_psr <= b;
        div_dividend <= a;
        div_divisor <= b;
        div_signed <= (k == 7);
        mem_size <= a[1:0];
        mem_addr_low <= b[1:0];
        other_active <= a[0];
        high_priority_active <= a[0];
        {svc_exec, div_valid, mem_valid, entry_valid, return_valid,
            exc_return_thread, data_bus_fault} <= 7'h40 >> (k == 7 ? 1 : k);
        @(posedge clk_sys);
        {svc_exec, div_valid, mem_valid, entry_valid, return_valid,
            exc_return_thread, data_bus_fault} <= 7'h0;
        @(negedge clk_sys);
    endtask
    task automatic ev(input logic e, input logic [8:0] n);
        chk(exc_req, e);
        if (e) begin
            chk(exc_num, n);
        end
    endtask
    task automatic sts(input logic [31:0] exp);
        rd(STS, exp);
        wr(STS, 32'h3f, 4'h1);
        rd(STS, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        rd(CFG, trap_cfg_pkg::CONFIG_RESET);
        rd(SWI, 32'h0);
        rd(4'hc, 32'h0);
        wr(CFG, 32'hffffffff);
        rd(CFG, trap_cfg_pkg::CONFIG_WRITE_MASK);
        wr(CFG, 32'h0, 4'h1);
        rd(CFG, 32'h300);
        $display("test registers done");
        wr(CFG, 32'h0);
        pulse(0, 32'hff, 32'ha);
        ev(1'h1, trap_cfg_pkg::EXC_SVC);
        chk(flags_out, 32'ha);
        sts(32'h4);
        pulse(1, 32'h64, 32'h0);
        ev(1'h0, USG);
        chk(div_done, 32'h1);
        chk(div_quotient, 32'h0);
        pulse(1, 32'h64, 32'h7);
        chk(div_quotient, 32'he);
        pulse(7, 32'hffffff9c, 32'h7);
        chk(div_quotient, 32'hfffffff2);
        wr(CFG, 32'h10);
        pulse(1, 32'h64, 32'h0);
        ev(1'h1, USG);
        sts(32'h1);
        $display("test call and divide done");
        wr(CFG, 32'h8);
        pulse(2, trap_cfg_pkg::SIZE_HALF, 32'h1);
        ev(1'h1, USG);
        pulse(2, trap_cfg_pkg::SIZE_BYTE, 32'h3);
        ev(1'h0, USG);
        pulse(2, trap_cfg_pkg::SIZE_WORD, 32'h0);
        ev(1'h0, USG);
        sts(32'h2);
        wr(CFG, 32'h0);
        pulse(2, trap_cfg_pkg::SIZE_WORD, 32'h2);
        ev(1'h0, USG);
        $display("test misalign done");
        pulse(3, 32'h20000004, 32'h01000000);
        chk(frame_sp, 32'h20000004);
        chk(stacked_psr, 32'h01000000);
        wr(CFG, 32'h200);
        pulse(3, 32'h20000004, 32'h01000000);
        chk(frame_sp, 32'h20000000);
        chk(stacked_psr, 32'h01000200);
        pulse(4, 32'h20000000, 32'h01000200);
        chk(restored_sp, 32'h20000004);
        pulse(4, 32'h20000010, 32'h01000000);
        chk(restored_sp, 32'h20000010);
        $display("test stack done");
        wr(CFG, 32'h0);
        pulse(5, 32'h1, 32'h0);
        chk(thread_entry_fault, 32'h1);
        wr(CFG, 32'h1);
        pulse(5, 32'h1, 32'h0);
        chk(thread_entry_fault, 32'h0);
        wr(CFG, 32'h0);
        @(posedge clk_sys);
        bus_privileged <= 1'h0;
        wr(SWI, 32'h23);
        @(negedge clk_sys);
        chk(swint_valid, 32'h0);
        sts(32'h20);
        wr(CFG, 32'h2);
        wr(SWI, 32'h23);
        @(negedge clk_sys);
        chk({swint_valid, swint_id}, {1'h1, 9'h023});
        $display("test thread and trigger done");
        wr(CFG, 32'h100);
        pulse(6, 32'h1, 32'h0);
        chk({bus_fault_suppress, lockup}, 32'h2);
        sts(32'h10);
        wr(CFG, 32'h0);
        pulse(6, 32'h0, 32'h0);
        chk({bus_fault_suppress, lockup}, 32'h0);
        pulse(6, 32'h1, 32'h0);
        chk({bus_fault_suppress, lockup}, 32'h1);
        pulse(5, 32'h0, 32'h0);
        chk(lockup, 32'h1);
        rd(STS, 32'h8);
        wr(CFG, trap_cfg_pkg::CONFIG_WRITE_MASK);
        @(posedge clk_sys);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(negedge clk_sys);
        chk(lockup, 32'h0);
        rd(CFG, trap_cfg_pkg::CONFIG_RESET);
        $display("test bus fault done");
        results();
    end
endmodule

// ==== verification/trap_and_fault_config_monitor.sv ====
`timescale 1ns/1ps
module trap_and_fault_config_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Instruction and fault events
    input wire logic svc_exec,
    input wire logic [3:0] flags_in,
    input wire logic [3:0] flags_out,
    input wire logic exc_req,
    input wire logic [8:0] exc_num,
    input wire logic lockup,
    input wire logic data_bus_fault,
    input wire logic high_priority_active,
    input wire logic bus_fault_suppress,
    input wire logic mem_valid,
    // Software trigger
    input wire logic avs_write,
    input wire logic [3:0] avs_address,
    input wire logic avs_waitrequest,
    input wire logic swint_valid,
    // Stack alignment
    input wire logic entry_valid,
    input wire logic [31:0] entry_sp,
    input wire logic [31:0] frame_sp,
    input wire logic [31:0] stacked_psr,
    input wire logic return_valid,
    input wire logic [31:0] return_frame_sp,
    input wire logic [31:0] return_stacked_psr,
    input wire logic [31:0] restored_sp,
    // Divide
    input wire logic div_valid,
    input wire logic div_signed,
    input wire logic [31:0] div_dividend,
    input wire logic [31:0] div_divisor,
    input wire logic div_done,
    input wire logic [31:0] div_quotient
);
    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_svc_raises_exc:
    assert property (svc_exec && !div_valid && !mem_valid && !lockup
        |=> exc_req && exc_num == trap_cfg_pkg::EXC_SVC)
        else $error("call did not raise its exception");
    a_flags_kept:
    assert property (flags_out == flags_in)
        else $error("condition flags changed");
    a_entry_pad_rec:
    assert property (entry_valid |=> frame_sp == (stacked_psr[9] ?
        ($past(entry_sp) & 32'hfffffffb) : $past(entry_sp))
        && (stacked_psr[9] -> $past(entry_sp[2])))
        else $error("entry pad not matched to stacked bit");
    a_return_restore:
    assert property (return_valid |=> restored_sp ==
        ($past(return_stacked_psr[9]) ? ($past(return_frame_sp) | 32'h4)
        : $past(return_frame_sp)))
        else $error("restored pointer wrong");
    a_fault_one_way:
    assert property (data_bus_fault && high_priority_active && !lockup
        |=> bus_fault_suppress != lockup)
        else $error("high priority fault handled neither way");
    a_lockup_cause:
    assert property ($rose(lockup)
        |-> $past(data_bus_fault && high_priority_active))
        else $error("lockup without its cause");
    a_lockup_sticky:
    assert property (lockup |=> lockup)
        else $error("lockup released");
    a_divzero_out:
    assert property (div_valid && div_divisor == 32'h0 |=>
        (exc_req && exc_num == trap_cfg_pkg::EXC_USAGE)
        || (div_done && div_quotient == 32'h0))
        else $error("zero divisor neither trapped nor zeroed");
    a_unsigned_divide_result:
    assert property (div_valid && !div_signed && div_divisor != 32'h0
        |=> div_done && div_quotient == $past(div_dividend)
        / $past(div_divisor))
        else $error("unsigned quotient wrong");
    // trigger only from a taken write
    a_swint_source:
    assert property (swint_valid |-> $past(avs_write && !avs_waitrequest
        && avs_address == trap_cfg_pkg::REG_SWINT_OFS))
        else $error("trigger without a write");
endmodule
bind trap_and_fault_config trap_and_fault_config_monitor mon (.*);
